// [logic/owdcs_pkg.sv]
// Package for the oscillator watchdog and clock select block
// Assumes one system clock and an Avalon-MM register slave
package owdcs_pkg;
	// Register byte offsets
	localparam logic [3:0] ADDR_CONFIG  = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h4;
	localparam logic [3:0] ADDR_MASK    = 4'h8;
	localparam logic [3:0] ADDR_BUSCFG  = 4'hc;
	// Field positions
	localparam int DISABLE_BIT = 4;
	localparam int ALE_LSB     = 0;
	localparam int WAIT_LSB    = 4;
	localparam int TRI_BIT     = 8;
	// Reset values
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] BUSCFG_RESET = 32'h0000_0000;
	// Watchdog overflow count
	localparam int WDOG_LIMIT = 16;
	localparam logic [3:0] WAIT_BASE = 4'hf;
	// Strap codes
	localparam logic [2:0] STRAP_DIRECT    = 3'h3;
	localparam logic [2:0] STRAP_PRESCALE  = 3'h1;
	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_PRESCALE,
		MODE_PLL,
		MODE_BACKUP
	} owdcs_mode_type;
endpackage : owdcs_pkg

// [logic/owdcs_edge.sv]
// Two-flop synchroniser with transition detector
// Assumes the sampled input is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module owdcs_edge (
	// System
	input  wire logic clock,
	input  wire logic rst,
	// Signal
	input  wire logic sig_in,
	output logic      toggle
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= sig_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign toggle = s2_q ^ s3_q;
endmodule : owdcs_edge
`default_nettype wire

// [logic/owdcs_top.sv]
// Oscillator watchdog, clock source select and bus timing variables
// Assumes clock stands for the free-running backup oscillator clock
// Functional notes
// - Watchdog enabled after reset by default
// - Config bit 4 set disables watchdog
// - Enabled watchdog counts every backup clock
// - Crystal transition clears the watchdog counter
// - Sixteen counts without transition means failure
// - Failure selects backup clock, raises interrupt
// - Backup selection holds until hardware reset
// - Disabled watchdog: crystal clock, backup off except in multiplier mode
// - Other strap codes enable multiplier mode
// - Resync multiplier every F-th input transition
// - Latch extension equals half-periods times field
// - Wait time is 2 half-periods times 15-count
// - Tristate time 2 half-periods times 1-bit
// - Straps: 011 direct, 001 prescale, else factor
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module owdcs_top (
	// System
	input  wire logic        clock,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Clock inputs
	input  wire logic        crystal_input,
	input  wire logic [2:0]  clock_mode_strap_pins,
	// Clock control
	output logic             backup_osc_enable,
	output logic             cpu_clock_backup,
	output logic [1:0]       cpu_clock_mode,
	output logic [3:0]       pll_factor_x2,
	output logic             pll_resync,
	// Bus timing in half-clock periods
	output logic [1:0]       latch_ext_half_clocks,
	output logic [5:0]       wait_half_clocks,
	output logic [1:0]       tristate_half_clocks,
	// Interrupt
	output logic             clock_fail_irq
);
	// Registers
	logic [31:0] config_q;
	logic [31:0] busreg_q;
	logic        irq_mask_q;
	logic        fail_flag_q;
	logic [4:0]  wdog_q;
	logic        backup_q;
	logic [2:0]  clock_mode_straps_q;
	logic        strap_done_q;
	logic [3:0]  resync_q;
	logic        ack_q;
	logic        xtal_edge;

	owdcs_edge u_edge (
		.clock  (clock),
		.rst    (rst),
		.sig_in (crystal_input),
		.toggle (xtal_edge)
	);

	// Decode
	wire acc     = (read | write) & ~ack_q;
	wire wr_cfg  = write & acc & (address == owdcs_pkg::ADDR_CONFIG);
	wire wr_msk  = write & acc & (address == owdcs_pkg::ADDR_MASK);
	wire wr_bus  = write & acc & (address == owdcs_pkg::ADDR_BUSCFG);
	wire rd_stat = read & acc & (address == owdcs_pkg::ADDR_STATUS);
	wire wd_off  = config_q[owdcs_pkg::DISABLE_BIT];
	wire overflow = ~wd_off & ~backup_q &
		(wdog_q == 5'(owdcs_pkg::WDOG_LIMIT - 1)) & ~xtal_edge;
	wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	wire [31:0] rd_mux =
		(address == owdcs_pkg::ADDR_CONFIG) ? config_q :
		(address == owdcs_pkg::ADDR_STATUS) ? {31'h0, fail_flag_q} :
		(address == owdcs_pkg::ADDR_MASK)   ? {31'h0, irq_mask_q} :
		(address == owdcs_pkg::ADDR_BUSCFG) ? busreg_q : 32'h0000_0000;

	// Strap decode
	wire is_direct = clock_mode_straps_q == owdcs_pkg::STRAP_DIRECT;
	wire is_presc  = clock_mode_straps_q == owdcs_pkg::STRAP_PRESCALE;
	logic [3:0] factor_x2;
	always_comb begin
		case (clock_mode_straps_q)
			3'h7:    factor_x2 = 4'h8;
			3'h6:    factor_x2 = 4'h6;
			3'h5:    factor_x2 = 4'h4;
			3'h4:    factor_x2 = 4'ha;
			3'h2:    factor_x2 = 4'h3;
			3'h0:    factor_x2 = 4'h5;
			default: factor_x2 = 4'h2;
		endcase
	end
	wire pll_mode = ~is_direct & ~is_presc;
	// Resync every F-th input transition, F rounded up
	wire [3:0] f_whole = 4'((factor_x2 + 4'h1) >> 1);

	// Bus slave: one wait state per access
	always_ff @(posedge clock) begin
		if (rst) begin
			ack_q <= 1'b0;
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else begin
			ack_q <= acc;
			waitrequest <= ~acc;
			if (acc)
				readdata <= read ? rd_mux : 32'h0000_0000;
		end
	end

	// Config and bus registers
	always_ff @(posedge clock) begin
		if (rst) begin
			config_q <= owdcs_pkg::CONFIG_RESET;
			busreg_q <= owdcs_pkg::BUSCFG_RESET;
			irq_mask_q <= 1'b0;
		end else begin
			if (wr_cfg)
				config_q <= (config_q & ~be_mask) | (writedata & be_mask);
			if (wr_bus)
				busreg_q <= (busreg_q & ~be_mask) | (writedata & be_mask);
			if (wr_msk & byteenable[0])
				irq_mask_q <= writedata[0];
		end
	end

	// Straps caught at the first edge after reset release
	always_ff @(posedge clock) begin
		if (rst) begin
			strap_done_q <= 1'b0;
			clock_mode_straps_q <= 3'h0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			clock_mode_straps_q <= clock_mode_strap_pins;
		end
	end

	// Watchdog counter
	always_ff @(posedge clock) begin
		if (rst)
			wdog_q <= 5'h00;
		else if (wd_off || backup_q || xtal_edge)
			wdog_q <= 5'h00;
		else if (wdog_q != 5'(owdcs_pkg::WDOG_LIMIT - 1))
			wdog_q <= wdog_q + 5'h01;
	end

	// Failover and sticky flag
	always_ff @(posedge clock) begin
		if (rst) begin
			backup_q <= 1'b0;
			fail_flag_q <= 1'b0;
		end else begin
			if (overflow)
				backup_q <= 1'b1;
			if (overflow)
				fail_flag_q <= 1'b1;
			else if (rd_stat)
				fail_flag_q <= 1'b0;
		end
	end

	// Multiplier resynchronisation
	always_ff @(posedge clock) begin
		if (rst) begin
			resync_q <= 4'h0;
			pll_resync <= 1'b0;
		end else begin
			pll_resync <= 1'b0;
			if (pll_mode && xtal_edge && !backup_q) begin
				if (resync_q >= f_whole - 4'h1) begin
					resync_q <= 4'h0;
					pll_resync <= 1'b1;
				end else
					resync_q <= resync_q + 4'h1;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clock) begin
		if (rst) begin
			backup_osc_enable <= 1'b1;
			cpu_clock_backup <= 1'b0;
			cpu_clock_mode <= 2'h0;
			pll_factor_x2 <= 4'h2;
			latch_ext_half_clocks <= 2'h0;
			wait_half_clocks <= 6'h00;
			tristate_half_clocks <= 2'h0;
			clock_fail_irq <= 1'b0;
		end else begin
			backup_osc_enable <= ~wd_off | pll_mode;
			cpu_clock_backup <= backup_q | overflow;
			if (backup_q)
				cpu_clock_mode <= owdcs_pkg::MODE_BACKUP;
			else if (pll_mode)
				cpu_clock_mode <= owdcs_pkg::MODE_PLL;
			else if (is_presc)
				cpu_clock_mode <= owdcs_pkg::MODE_PRESCALE;
			else
				cpu_clock_mode <= owdcs_pkg::MODE_DIRECT;
			pll_factor_x2 <= factor_x2;
			latch_ext_half_clocks <=
				busreg_q[owdcs_pkg::ALE_LSB +: 2];
			wait_half_clocks <= {1'b0, owdcs_pkg::WAIT_BASE -
				busreg_q[owdcs_pkg::WAIT_LSB +: 4], 1'b0};
			tristate_half_clocks <=
				{~busreg_q[owdcs_pkg::TRI_BIT], 1'b0};
			clock_fail_irq <= fail_flag_q & irq_mask_q;
		end
	end

	// Assertions
	a_wdog_clear: assert property (@(posedge clock) disable iff (rst)
		xtal_edge |=> wdog_q == 5'h00)
		else $error("watchdog not cleared by transition");
	a_wdog_count: assert property (@(posedge clock) disable iff (rst)
		(!wd_off && !backup_q && !xtal_edge && wdog_q < 5'd15)
		|=> wdog_q == $past(wdog_q) + 5'h01)
		else $error("watchdog did not count");
	a_fail_after: assert property (@(posedge clock) disable iff (rst)
		(!wd_off && !backup_q && !xtal_edge && wdog_q == 5'd15)
		|=> backup_q && fail_flag_q)
		else $error("overflow did not fail over");
	a_switch_out: assert property (@(posedge clock) disable iff (rst)
		overflow |=> ##1 cpu_clock_backup &&
		cpu_clock_mode == owdcs_pkg::MODE_BACKUP)
		else $error("cpu clock not switched to backup");
	a_backup_hold: assert property (@(posedge clock) disable iff (rst)
		backup_q |=> backup_q)
		else $error("backup released without reset");
	a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
		(fail_flag_q && !rd_stat) |=> fail_flag_q)
		else $error("failure flag lost");
	a_disable_bit: assert property (@(posedge clock) disable iff (rst)
		wd_off |=> wdog_q == 5'h00 && !overflow)
		else $error("disabled watchdog still active");
	a_reset_enable: assert property (@(posedge clock)
		$fell(rst) |-> !wd_off)
		else $error("watchdog not enabled after reset");
	a_osc_off: assert property (@(posedge clock) disable iff (rst)
		(wd_off && !pll_mode) |=> !backup_osc_enable)
		else $error("backup oscillator left on");
	a_tristate: assert property (@(posedge clock) disable iff (rst)
		$past(busreg_q[owdcs_pkg::TRI_BIT]) |-> tristate_half_clocks == 2'h0)
		else $error("tristate time wrong");
endmodule : owdcs_top
`default_nettype wire

// [dv/owdcs_xtal.sv]
// Crystal oscillator model, toggles every four clocks while run is high
// Assumes clock is the bench clock; a stopped crystal holds its level
`timescale 1ns/1ps
`default_nettype none
module owdcs_xtal (
	// System
	input  wire logic clock,
	// Control
	input  wire logic run,
	// Crystal
	output logic      xtal
);
	logic [1:0] cnt_q = 2'h0;
	initial xtal = 1'b0;
	always @(posedge clock) begin
		if (run) begin
			cnt_q <= cnt_q + 2'h1;
			if (cnt_q == 2'h3) xtal <= ~xtal;
		end
	end
endmodule : owdcs_xtal
`default_nettype wire

// [dv/tb.sv]
// Testbench for the clock supervisor and selector
// Assumes the crystal model and an Avalon-MM master in the bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module tb;
	logic        clock, rst, read, write, run, wr, bo, cb, rs_p, irq;
	logic [3:0]  address, byteenable, fx2;
	logic [31:0] writedata, rdata, q;
	logic [2:0]  straps;
	logic [1:0]  md, le, th;
	logic [5:0]  wh;
	logic        xt;
	int          checked, n_mismatch, cyc, i, np;
	logic [3:0]  fx [0:7] = '{4'h5, 4'h2, 4'h3, 4'h2, 4'ha, 4'h4, 4'h6, 4'h8};
	logic [1:0]  mx [0:7] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2};
	owdcs_xtal xtal_u (.clock(clock), .run(run), .xtal(xt));
	owdcs_top dut_u (.clock(clock), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(rdata), .waitrequest(wr),
		.crystal_input(xt), .clock_mode_strap_pins(straps),
		.backup_osc_enable(bo), .cpu_clock_backup(cb),
		.cpu_clock_mode(md), .pll_factor_x2(fx2), .pll_resync(rs_p),
		.latch_ext_half_clocks(le), .wait_half_clocks(wh),
		.tristate_half_clocks(th), .clock_fail_irq(irq));
	always #25 clock = ~clock;
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		address <= a;
		writedata <= d;
		read <= ~w;
		write <= w;
		@(posedge clock);
		while (wr !== 1'b0) @(posedge clock);
		q = rdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic rs(input logic [2:0] s);
		straps <= s;
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : rs
	task report_and_stop;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop;
		end
	end
	initial begin
		clock = 0; rst = 1; address = 0; read = 0; write = 0;
		writedata = 0; byteenable = 4'hf; straps = 3'h3; run = 1;
		for (i = 0; i < 8; i++) begin
			rs(i[2:0]);
			`CHK(md, mx[i])
			`CHK(fx2, fx[i])
			`CHK(bo, 1'b1)
		end
		$display("test straps done");
		rs(3'h7);
		repeat (20) @(posedge clock);
		np = 0;
		repeat (64) begin
			@(posedge clock);
			np += rs_p;
		end
		`CHK(np, 4)
		$display("test resync done");
		rs(3'h3);
		bus(1'b1, owdcs_pkg::ADDR_BUSCFG, 32'h0000_0153);
		repeat (2) @(posedge clock);
		`CHK(le, 2'h3)
		`CHK(wh, 6'h14)
		`CHK(th, 2'h0)
		bus(1'b1, owdcs_pkg::ADDR_BUSCFG, 32'h0000_00f0);
		repeat (2) @(posedge clock);
		`CHK(wh, 6'h00)
		`CHK(th, 2'h2)
		bus(1'b0, owdcs_pkg::ADDR_BUSCFG, 32'h0);
		`CHK(q, 32'h0000_00f0)
		bus(1'b0, 4'h2, 32'h0);
		`CHK(q, 32'h0)
		$display("test bus timing done");
		bus(1'b1, owdcs_pkg::ADDR_MASK, 32'h1);
		repeat (60) @(posedge clock);
		`CHK(cb, 1'b0)
		run <= 1'b0;
		repeat (12) @(posedge clock);
		`CHK(cb, 1'b0)
		repeat (18) @(posedge clock);
		`CHK(cb, 1'b1)
		`CHK(md, 2'h3)
		`CHK(irq, 1'b1)
		run <= 1'b1;
		repeat (40) @(posedge clock);
		`CHK(cb, 1'b1)
		`CHK(irq, 1'b1)
		bus(1'b0, owdcs_pkg::ADDR_STATUS, 32'h0);
		`CHK(q[0], 1'b1)
		repeat (2) @(posedge clock);
		`CHK(irq, 1'b0)
		$display("test failover done");
		rs(3'h3);
		`CHK(cb, 1'b0)
		run <= 1'b0;
		repeat (30) @(posedge clock);
		`CHK(irq, 1'b0)
		bus(1'b0, owdcs_pkg::ADDR_STATUS, 32'h0);
		`CHK(q, 32'h1)
		run <= 1'b1;
		rs(3'h3);
		bus(1'b1, owdcs_pkg::ADDR_CONFIG, 32'h10);
		repeat (2) @(posedge clock);
		`CHK(bo, 1'b0)
		run <= 1'b0;
		repeat (40) @(posedge clock);
		`CHK(cb, 1'b0)
		`CHK(md, 2'h0)
		$display("test disable done");
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
